/* design/adc_buffer_alert_config_regs.sv */
// Buffer, alert and window comparator configuration registers of the ADC.
// Assumes a same-clock register port and conversion results from the core.
module adc_buffer_alert_config_regs
  import adc_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst,
  // Register port
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [DATA_W-1:0]   reg_wdata,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  output logic      [DATA_W-1:0]   reg_rdata,
  // Conversion input from the core
  input  wire logic                conv_valid,
  input  wire logic [RESULT_W-1:0] conv_result,
  input  wire logic                conv_channel,
  // Configuration outputs
  output logic      [2:0]          capture_mode_select,
  output logic                     capture_running,
  output logic                     accumulator_on,
  output logic                     alert_enable_chan0,
  output logic                     alert_enable_chan1,
  output logic                     window_comparator_on,
  output logic      [RESULT_W-1:0] chan0_high_limit,
  // Buffer word output
  output logic      [WORD_W-1:0]   buffer_word,
  output logic                     buffer_word_valid,
  // Interrupt
  output logic                     irq
);

  typedef struct packed {
    logic [1:0]          word_format;
    logic [2:0]          capture_mode;
    logic [3:0]          accumulator_enable_field;
    logic [1:0]          alert_enable;
    logic [3:0]          prealert_events_minus_one;
    logic                window_on;
    logic [7:0]          chan0_high_limit_low_byte;
    logic [3:0]          chan0_high_limit_high_nibble;
    logic [7:0]          irq_status;
    logic [7:0]          irq_mask;
    logic [DATA_W-1:0]   rdata;
    logic [WORD_W-1:0]   word;
    logic                word_valid;
    logic                running;
    logic                post_armed;
    logic                irq;
    logic                acc_on;
  } state_t;

  state_t             state_reg;
  state_t             state_next;
  logic [WORD_W-1:0]  packed_word;
  logic               ch0_over;
  logic               prealert_hit;
  logic [7:0]         irq_events;

  function automatic logic [7:0] masked(input logic [7:0] value,
                                        input logic [7:0] mask);
    masked = value & mask;
  endfunction

  buffer_word_packer u_packer (
    .format     (state_reg.word_format),
    .result     (conv_result),
    .channel    (conv_channel),
    .data_valid (conv_valid),
    .word       (packed_word)
  );

  // Window check on channel 0 against the high limit.
  always_comb begin
    ch0_over = conv_valid && !conv_channel && state_reg.window_on
      && state_reg.alert_enable[POS_ALERT_CH0]
      && (conv_result > {state_reg.chan0_high_limit_high_nibble,
                         state_reg.chan0_high_limit_low_byte});
  end

  prealert_counter u_prealert (
    .ref_clk          (ref_clk),
    .rst              (rst),
    .enable           (state_reg.capture_mode == CAP_PRE_ALERT),
    .events_minus_one (state_reg.prealert_events_minus_one),
    .event_hit        (ch0_over),
    .event_miss       (conv_valid && !conv_channel && !ch0_over),
    .reached          (prealert_hit)
  );

  always_comb begin
    state_next = state_reg;
    irq_events = 8'h00;
    state_next.word_valid = 1'b0;

    // Capture: bursts run in start mode and pre-alert mode always runs; post-alert runs once armed.
    case (state_reg.capture_mode)
      CAP_STOP_BURST:  state_next.running = 1'b0;
      CAP_START_BURST: state_next.running = 1'b1;
      CAP_PRE_ALERT:   state_next.running = 1'b1;
      CAP_POST_ALERT: begin
        if (ch0_over) begin
          state_next.post_armed = 1'b1;
        end
        state_next.running = state_reg.post_armed;
      end
      default:         state_next.running = 1'b0;
    endcase
    if (conv_valid && state_reg.running) begin
      state_next.word = packed_word;
      state_next.word_valid = 1'b1;
      irq_events[IRQ_WORD_DONE] = 1'b1;
    end
    irq_events[IRQ_CH0_HIGH] = ch0_over;
    irq_events[IRQ_PREALERT] = prealert_hit;

    // Register writes keep only the writable fields.
    if (reg_write) begin
      if (reg_addr == OFS_WORD_FORMAT) begin
        state_next.word_format = reg_wdata[1:0];
      end else if (reg_addr == OFS_CAPTURE_MODE) begin
        state_next.capture_mode = reg_wdata[2:0];
        state_next.post_armed = 1'b0;
      end else if (reg_addr == OFS_ACC_CONTROL) begin
        state_next.accumulator_enable_field = reg_wdata[3:0];
      end else if (reg_addr == OFS_ALERT_CH_EN) begin
        state_next.alert_enable = reg_wdata[1:0];
      end else if (reg_addr == OFS_PREALERT_EVENTS_MINUS_ONE) begin
        state_next.prealert_events_minus_one =
          reg_wdata[POS_PREALERT +: 4];
      end else if (reg_addr == OFS_WINDOW_CMP_EN) begin
        state_next.window_on = reg_wdata[POS_WINDOW_ON];
      end else if (reg_addr == OFS_CH0_HTH_LOW) begin
        state_next.chan0_high_limit_low_byte = reg_wdata;
      end else if (reg_addr == OFS_CH0_HTH_HIGH) begin
        state_next.chan0_high_limit_high_nibble = reg_wdata[3:0];
      end else if (reg_addr == OFS_IRQ_MASK) begin
        state_next.irq_mask = masked(reg_wdata, MASK_IRQ);
      end
    end

    // Decoded here so the enable output comes straight from a flop.
    state_next.acc_on =
      (state_next.accumulator_enable_field == ACC_ON);

    // Sticky status: a new event wins over a write-one clear.
    state_next.irq_status = masked(state_reg.irq_status, MASK_IRQ);
    if (reg_write && reg_addr == OFS_IRQ_STATUS) begin
      state_next.irq_status = state_next.irq_status & ~reg_wdata;
    end
    state_next.irq_status = masked(state_next.irq_status | irq_events,
                                   MASK_IRQ);
    state_next.irq = |(state_next.irq_status & state_next.irq_mask);

    // Reads: reserved bits and unmapped offsets return zero.
    state_next.rdata = 8'h00;
    if (reg_read) begin
      if (reg_addr == OFS_WORD_FORMAT) begin
        state_next.rdata = masked({6'h00, state_reg.word_format},
                                  MASK_WORD_FORMAT);
      end else if (reg_addr == OFS_CAPTURE_MODE) begin
        state_next.rdata = masked({5'h00, state_reg.capture_mode},
                                  MASK_CAPTURE_MODE);
      end else if (reg_addr == OFS_ACC_CONTROL) begin
        state_next.rdata = masked({4'h0, state_reg.accumulator_enable_field},
                                  MASK_ACC_CONTROL);
      end else if (reg_addr == OFS_ALERT_CH_EN) begin
        state_next.rdata = masked({6'h00, state_reg.alert_enable},
                                  MASK_ALERT_CH_EN);
      end else if (reg_addr == OFS_PREALERT_EVENTS_MINUS_ONE) begin
        state_next.rdata = masked({state_reg.prealert_events_minus_one, 4'h0},
                                  MASK_PREALERT_EVENTS_MINUS_ONE);
      end else if (reg_addr == OFS_WINDOW_CMP_EN) begin
        state_next.rdata = masked({7'h00, state_reg.window_on},
                                  MASK_WINDOW_CMP_EN);
      end else if (reg_addr == OFS_CH0_HTH_LOW) begin
        state_next.rdata = masked(state_reg.chan0_high_limit_low_byte,
                                  MASK_CH0_HTH_LOW);
      end else if (reg_addr == OFS_CH0_HTH_HIGH) begin
        state_next.rdata = masked({4'h0,
                                   state_reg.chan0_high_limit_high_nibble},
                                  MASK_CH0_HTH_HIGH);
      end else if (reg_addr == OFS_IRQ_STATUS) begin
        state_next.rdata = state_reg.irq_status;
      end else if (reg_addr == OFS_IRQ_MASK) begin
        state_next.rdata = state_reg.irq_mask;
      end else if (reg_addr == OFS_BUF_WORD_LOW) begin
        state_next.rdata = state_reg.word[7:0];
      end else if (reg_addr == OFS_BUF_WORD_HIGH) begin
        state_next.rdata = state_reg.word[15:8];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.word_format <= RST_WORD_FORMAT[1:0];
      state_reg.capture_mode <= RST_CAPTURE_MODE[2:0];
      state_reg.accumulator_enable_field <= RST_ACC_CONTROL[3:0];
      state_reg.alert_enable <= RST_ALERT_CH_EN[1:0];
      state_reg.prealert_events_minus_one <= RST_PREALERT_EVENTS_MINUS_ONE[7:4];
      state_reg.window_on <= RST_WINDOW_CMP_EN[0];
      state_reg.chan0_high_limit_low_byte <= RST_CH0_HTH;
      state_reg.chan0_high_limit_high_nibble <= RST_CH0_HTH[3:0];
      state_reg.irq_status <= RST_IRQ;
      state_reg.irq_mask <= RST_IRQ;
    end else begin
      state_reg <= state_next;
    end
  end

  // Configuration outputs track the register copies directly.
  always_comb begin
    reg_rdata = state_reg.rdata;
    capture_mode_select = state_reg.capture_mode;
    capture_running = state_reg.running;
    // Reserved accumulator codes leave the accumulator off, the safe side.
    accumulator_on = state_reg.acc_on;
    alert_enable_chan0 = state_reg.alert_enable[POS_ALERT_CH0];
    alert_enable_chan1 = state_reg.alert_enable[POS_ALERT_CH1];
    window_comparator_on = state_reg.window_on;
    chan0_high_limit = {state_reg.chan0_high_limit_high_nibble,
                        state_reg.chan0_high_limit_low_byte};
    buffer_word = state_reg.word;
    buffer_word_valid = state_reg.word_valid;
    irq = state_reg.irq;
  end

endmodule // adc_buffer_alert_config_regs

/* design/adc_cfg_pkg.sv */
// Package for the ADC buffer, alert and comparator configuration registers.
// Assumes an 8-bit register port with one-cycle read latency.
package adc_cfg_pkg;

  localparam int          ADDR_W = 8;
  localparam int          DATA_W = 8;
  localparam int          RESULT_W = 12;
  localparam int          WORD_W = 16;

  // Register offsets.
  localparam logic [7:0]  OFS_WORD_FORMAT    = 8'h28;
  localparam logic [7:0]  OFS_CAPTURE_MODE   = 8'h2C;
  localparam logic [7:0]  OFS_ACC_CONTROL    = 8'h30;
  localparam logic [7:0]  OFS_ALERT_CH_EN    = 8'h34;
  localparam logic [7:0]  OFS_PREALERT_EVENTS_MINUS_ONE = 8'h36;
  localparam logic [7:0]  OFS_WINDOW_CMP_EN  = 8'h37;
  localparam logic [7:0]  OFS_CH0_HTH_LOW    = 8'h38;
  localparam logic [7:0]  OFS_CH0_HTH_HIGH   = 8'h39;
  localparam logic [7:0]  OFS_IRQ_STATUS     = 8'h70;
  localparam logic [7:0]  OFS_IRQ_MASK       = 8'h71;
  localparam logic [7:0]  OFS_BUF_WORD_LOW   = 8'h72;
  localparam logic [7:0]  OFS_BUF_WORD_HIGH  = 8'h73;

  // Writable field masks; zero bits are reserved.
  localparam logic [7:0]  MASK_WORD_FORMAT    = 8'h03;
  localparam logic [7:0]  MASK_CAPTURE_MODE   = 8'h07;
  localparam logic [7:0]  MASK_ACC_CONTROL    = 8'h0F;
  localparam logic [7:0]  MASK_ALERT_CH_EN    = 8'h03;
  localparam logic [7:0]  MASK_PREALERT_EVENTS_MINUS_ONE = 8'hF0;
  localparam logic [7:0]  MASK_WINDOW_CMP_EN  = 8'h01;
  localparam logic [7:0]  MASK_CH0_HTH_LOW    = 8'hFF;
  localparam logic [7:0]  MASK_CH0_HTH_HIGH   = 8'h0F;
  localparam logic [7:0]  MASK_IRQ            = 8'h07;

  // Field positions.
  localparam int          POS_PREALERT = 4;
  localparam int          POS_ALERT_CH1 = 1;
  localparam int          POS_ALERT_CH0 = 0;
  localparam int          POS_WINDOW_ON = 0;
  localparam int          IRQ_WORD_DONE = 0;
  localparam int          IRQ_CH0_HIGH  = 1;
  localparam int          IRQ_PREALERT  = 2;

  // Reset values.
  localparam logic [7:0]  RST_WORD_FORMAT    = 8'h00;
  localparam logic [7:0]  RST_CAPTURE_MODE   = 8'h01;
  localparam logic [7:0]  RST_ACC_CONTROL    = 8'h00;
  localparam logic [7:0]  RST_ALERT_CH_EN    = 8'h00;
  localparam logic [7:0]  RST_PREALERT_EVENTS_MINUS_ONE = 8'h00;
  localparam logic [7:0]  RST_WINDOW_CMP_EN  = 8'h00;
  localparam logic [7:0]  RST_CH0_HTH        = 8'h00;
  localparam logic [7:0]  RST_IRQ            = 8'h00;

  // Word format codes.
  localparam logic [1:0]  FMT_ZERO_A  = 2'h0;
  localparam logic [1:0]  FMT_CHAN_ID = 2'h1;
  localparam logic [1:0]  FMT_ID_VALID = 2'h2;
  localparam logic [1:0]  FMT_ZERO_B  = 2'h3;
  localparam logic [2:0]  CHAN_ID_0   = 3'h0;
  localparam logic [2:0]  CHAN_ID_1   = 3'h1;

  // Accumulator enable codes.
  localparam logic [3:0]  ACC_OFF = 4'h0;
  localparam logic [3:0]  ACC_ON  = 4'hF;

  typedef enum logic [2:0] {
    CAP_STOP_BURST  = 3'b000,
    CAP_START_BURST = 3'b001,
    CAP_PRE_ALERT   = 3'b100,
    CAP_POST_ALERT  = 3'b110
  } capture_mode_t;

endpackage

/* design/buffer_word_packer.sv */
// Packs one conversion result into the 16-bit buffer word format.
// Assumes result, channel and valid are steady for the cycle they are used.
module buffer_word_packer
  import adc_cfg_pkg::*;
(
  // Format selection
  input  wire logic [1:0]          format,
  // Conversion data
  input  wire logic [RESULT_W-1:0] result,
  input  wire logic                channel,
  input  wire logic                data_valid,
  // Packed word
  output logic      [WORD_W-1:0]   word
);

  logic [2:0] chan_id;

  always_comb begin
    chan_id = channel ? CHAN_ID_1 : CHAN_ID_0;
    case (format)
      FMT_CHAN_ID:  word = {result, chan_id, 1'b0};
      FMT_ID_VALID: word = {result, chan_id, data_valid};
      default:      word = {result, 4'h0};
    endcase
  end

endmodule // buffer_word_packer

/* design/prealert_counter.sv */
// Counts consecutive alert events before the pre-alert interrupt event fires.
// Assumes events arrive as one-cycle pulses on the same clock.
module prealert_counter
  import adc_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Control
  input  wire logic       enable,
  input  wire logic [3:0] events_minus_one,
  input  wire logic       event_hit,
  input  wire logic       event_miss,
  // Result
  output logic            reached
);

  typedef struct packed {
    logic [4:0] count;
    logic       reached;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [4:0] target;

  always_comb begin
    state_next = state_reg;
    target = {1'b0, events_minus_one} + 5'h01;
    state_next.reached = 1'b0;
    if (!enable || event_miss) begin
      state_next.count = 5'h00;
    end else if (event_hit) begin
      if (state_reg.count + 5'h01 >= target) begin
        state_next.reached = 1'b1;
        state_next.count = 5'h00;
      end else begin
        state_next.count = state_reg.count + 5'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reached = state_reg.reached;

endmodule // prealert_counter

/* verification/cfg_regs_monitor.sv */
// Checker for the configuration register block, on its ports only.
// Assumes it is bound to the block from the bench top.
module cfg_regs_monitor
  import adc_cfg_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  // Conversion input
  input wire logic        conv_valid,
  input wire logic [11:0] conv_result,
  // Configuration and buffer outputs
  input wire logic [2:0]  capture_mode_select,
  input wire logic        capture_running,
  input wire logic        accumulator_on,
  input wire logic        alert_enable_chan0,
  input wire logic        alert_enable_chan1,
  input wire logic        window_comparator_on,
  input wire logic [11:0] chan0_high_limit,
  input wire logic [15:0] buffer_word,
  input wire logic        buffer_word_valid,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  wdata_q;
  logic [11:0] res_q;
  // Copies one cycle old, so the checks can slice them.
  always_ff @(posedge ref_clk) begin
    wdata_q <= reg_wdata;
    res_q   <= conv_result;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_reserved_zero: assert property (reg_read && reg_addr == OFS_WINDOW_CMP_EN
    |=> reg_rdata[7:1] == 7'h00) else $error("reserved bits read nonzero");
  a_limit_low: assert property (reg_write && reg_addr == OFS_CH0_HTH_LOW
    |=> chan0_high_limit[7:0] == wdata_q) else $error("limit low byte");
  a_limit_high: assert property (reg_write && reg_addr == OFS_CH0_HTH_HIGH
    |=> chan0_high_limit[11:8] == wdata_q[3:0]) else $error("limit nibble");
  a_mode_write: assert property (reg_write && reg_addr == OFS_CAPTURE_MODE
    |=> capture_mode_select == wdata_q[2:0]) else $error("capture mode");
  a_acc_code: assert property (reg_write && reg_addr == OFS_ACC_CONTROL
    |=> accumulator_on == (wdata_q[3:0] == ACC_ON)) else $error("acc enable");
  a_alert_bits: assert property (reg_write && reg_addr == OFS_ALERT_CH_EN
    |=> alert_enable_chan1 == wdata_q[1] && alert_enable_chan0 == wdata_q[0])
    else $error("alert enables");
  a_window_bit: assert property (reg_write && reg_addr == OFS_WINDOW_CMP_EN
    |=> window_comparator_on == wdata_q[0]) else $error("window enable");
  a_word_capture: assert property (conv_valid && capture_running
    |=> buffer_word_valid && buffer_word[15:4] == res_q)
    else $error("captured word result field");
  a_chan_id_top: assert property (buffer_word_valid |->
    buffer_word[3:2] == 2'b00) else $error("channel id upper bits");
  a_stop_holds: assert property (capture_mode_select == CAP_STOP_BURST [*2]
    |-> !capture_running) else $error("capture runs in stop mode");
  c_word: cover property (buffer_word_valid);
  c_irq: cover property ($rose(irq));
  c_acc: cover property (accumulator_on);
endmodule // cfg_regs_monitor

/* verification/conv_source.sv */
// Model of the conversion core that feeds results to the register block.
// Assumes the bench requests one conversion per send pulse.
module conv_source (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Request from the bench
  input  wire logic        send,
  input  wire logic [11:0] res_in,
  input  wire logic        ch_in,
  // Conversion output
  output logic             conv_valid,
  output logic [11:0]      conv_result,
  output logic             conv_channel
);
  timeunit 1ns;
  timeprecision 1ps;
  // Outside a pulse the data lines toggle, so stale data is never trusted.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      conv_valid   <= 1'b0;
      conv_result  <= 12'h000;
      conv_channel <= 1'b0;
    end else begin
      conv_valid   <= send;
      conv_result  <= send ? res_in : ~conv_result;
      conv_channel <= send ? ch_in : ~conv_channel;
    end
  end
endmodule // conv_source

/* verification/tb_top.sv */
// Self-checking bench for the configuration register block.
// Assumes the block answers reads one cycle late and packs words at once.
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %0t: got %h exp %h", $time, g, e); end end
module tb_top;
  import adc_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 0, rst = 1, reg_write = 0, reg_read = 0;
  logic        send = 0, ch_in = 0, rd_pend = 0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [11:0] res_in = 12'h000, r, conv_result, chan0_high_limit;
  logic [2:0]  capture_mode_select;
  logic [15:0] buffer_word;
  logic        conv_valid, conv_channel, capture_running, accumulator_on;
  logic        alert_enable_chan0, alert_enable_chan1, window_comparator_on;
  logic        buffer_word_valid, irq;
  integer      seed = 47241;
  int          miscompares = 0, n_checks = 0;
  logic [7:0]  rd_q[$];
  logic [15:0] word_q[$];
  localparam logic [7:0] ADR[8] = '{OFS_WORD_FORMAT, OFS_CAPTURE_MODE,
    OFS_ACC_CONTROL, OFS_ALERT_CH_EN, OFS_PREALERT_EVENTS_MINUS_ONE, OFS_WINDOW_CMP_EN,
    OFS_CH0_HTH_LOW, OFS_CH0_HTH_HIGH};
  localparam logic [7:0] RV[8] = '{RST_WORD_FORMAT, RST_CAPTURE_MODE,
    RST_ACC_CONTROL, RST_ALERT_CH_EN, RST_PREALERT_EVENTS_MINUS_ONE, RST_WINDOW_CMP_EN,
    RST_CH0_HTH, RST_CH0_HTH};
  localparam logic [7:0] MSK[8] = '{MASK_WORD_FORMAT, MASK_CAPTURE_MODE,
    MASK_ACC_CONTROL, MASK_ALERT_CH_EN, MASK_PREALERT_EVENTS_MINUS_ONE,
    MASK_WINDOW_CMP_EN, MASK_CH0_HTH_LOW, MASK_CH0_HTH_HIGH};
  localparam logic [2:0] MODES[4] = '{3'h0, 3'h1, 3'h4, 3'h6};
  always #4 ref_clk = ~ref_clk;
  adc_buffer_alert_config_regs dut (.ref_clk, .rst, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .conv_valid, .conv_result,
    .conv_channel, .capture_mode_select, .capture_running, .accumulator_on,
    .alert_enable_chan0, .alert_enable_chan1, .window_comparator_on,
    .chan0_high_limit, .buffer_word, .buffer_word_valid, .irq);
  conv_source src (.ref_clk, .rst, .send, .res_in, .ch_in, .conv_valid,
    .conv_result, .conv_channel);
  function automatic logic [15:0] pack(input logic [1:0] f,
                                       input logic [11:0] v, input logic c);
    case (f)
      2'h1: pack = {v, 2'h0, c, 1'b0};
      2'h2: pack = {v, 2'h0, c, 1'b1};
      default: pack = {v, 4'h0};
    endcase
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    rd_q.push_back(e);
    @(posedge ref_clk);
    reg_read <= 1'b0;
  endtask
  // An unexpected result pops an unknown, which never matches.
  task automatic conv(input logic [11:0] v, input logic c);
    @(posedge ref_clk);
    send <= 1'b1;
    res_in <= v;
    ch_in <= c;
    @(posedge ref_clk);
    send <= 1'b0;
  endtask
  // Each note is popped once into a local, so a mismatch cannot pop twice.
  always @(posedge ref_clk) begin : watch
    logic [7:0]  exp_b;
    logic [15:0] exp_w;
    exp_b = 8'hxx;
    exp_w = 16'hxxxx;
    if (!rst) begin
      if (rd_pend) begin
        if (rd_q.size() > 0) exp_b = rd_q.pop_front();
        `CHK(reg_rdata, exp_b)
      end
      if (buffer_word_valid) begin
        if (word_q.size() > 0) exp_w = word_q.pop_front();
        `CHK(buffer_word, exp_w)
      end
      rd_pend <= reg_read;
    end
  end
  task automatic tally_and_finish;
    if (miscompares == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(ADR[i], RV[i]);
      wr(ADR[i], i == 1 ? 8'hFE : 8'hFF);
      rd(ADR[i], (i == 1 ? 8'hFE : 8'hFF) & MSK[i]);
    end
    wr(8'h50, 8'hA5);
    rd(8'h50, 8'h00);
    @(negedge ref_clk);
    `CHK(accumulator_on, 1'b1)
    `CHK(chan0_high_limit, 12'hFFF)
    wr(OFS_ACC_CONTROL, 8'h00);
    @(negedge ref_clk);
    `CHK(accumulator_on, 1'b0)
    foreach (MODES[i]) begin
      wr(OFS_CAPTURE_MODE, {5'h00, MODES[i]});
      @(negedge ref_clk);
      `CHK(capture_mode_select, MODES[i])
    end
    wr(OFS_CAPTURE_MODE, 8'h01);
    for (int f = 0; f < 4; f++) begin
      wr(OFS_WORD_FORMAT, 8'(f));
      for (int c = 0; c < 2; c++) begin
        r = 12'($random(seed));
        word_q.push_back(pack(2'(f), r, c[0]));
        conv(r, c[0]);
      end
    end
    wr(OFS_CAPTURE_MODE, 8'h00);
    conv(12'($random(seed)), 1'b1);
    wr(OFS_CH0_HTH_LOW, 8'h00);
    wr(OFS_CH0_HTH_HIGH, 8'h08);
    wr(OFS_CAPTURE_MODE, 8'h06);
    conv(12'h100, 1'b0);
    conv(12'h900, 1'b0);
    repeat (3) @(posedge ref_clk);
    r = 12'($random(seed));
    word_q.push_back(pack(2'h3, r, 1'b1));
    conv(r, 1'b1);
    // Pre-alert mode keeps capturing, so each word is expected too.
    wr(OFS_IRQ_MASK, 8'h04);
    wr(OFS_PREALERT_EVENTS_MINUS_ONE, 8'h10);
    wr(OFS_CAPTURE_MODE, 8'h04);
    word_q.push_back(pack(2'h3, 12'h900, 1'b0));
    conv(12'h900, 1'b0);
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK(irq, 1'b0)
    word_q.push_back(pack(2'h3, 12'h900, 1'b0));
    conv(12'h900, 1'b0);
    for (int i = 0; i < 8 && irq !== 1'b1; i++) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK(irq, 1'b1)
    wr(OFS_IRQ_STATUS, 8'h07);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK(irq, 1'b0)
    rd(OFS_IRQ_STATUS, 8'h00);
    rd(OFS_BUF_WORD_HIGH, 8'h90);
    rd(OFS_BUF_WORD_LOW, 8'h00);
    repeat (4) @(posedge ref_clk);
    `CHK(word_q.size() + rd_q.size(), 0)
    tally_and_finish();
  end
endmodule // tb_top
bind adc_buffer_alert_config_regs cfg_regs_monitor mon (.ref_clk, .rst,
  .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .conv_valid,
  .conv_result, .capture_mode_select, .capture_running, .accumulator_on,
  .alert_enable_chan0, .alert_enable_chan1, .window_comparator_on,
  .chan0_high_limit, .buffer_word, .buffer_word_valid, .irq);
